// [common/ttm_pkg.sv]
// Package: constants, carriers and types for the two-tier interrupt mask unit
package ttm_pkg;

  // Register byte addresses on the APB
  localparam logic [31:0] TTM_ADDR_ENABLE_PLAIN = 32'hFFB0_0030;
  localparam logic [31:0] TTM_ADDR_ENABLE_SET = 32'hFFB0_0034;
  localparam logic [31:0] TTM_ADDR_ENABLE_CLEAR = 32'hFFB0_0038;

  // Bit layout shared by all three registers
  localparam int TTM_DMA_LSB = 19;
  localparam int TTM_DMA_COUNT = 13;
  localparam int TTM_ETH_RX_BIT = 17;
  localparam int TTM_ETH_TX_BIT = 16;
  localparam int TTM_SER_A_RX_BIT = 15;
  localparam int TTM_SER_A_TX_BIT = 14;
  localparam int TTM_SER_B_RX_BIT = 13;
  localparam int TTM_SER_B_TX_BIT = 12;
  localparam int TTM_MAC_BIT = 7;
  localparam int TTM_WDOG_BIT = 6;
  localparam int TTM_TIMER1_BIT = 5;
  localparam int TTM_TIMER2_BIT = 4;
  localparam int TTM_PORT_LSB = 0;
  localparam int TTM_PORT_COUNT = 4;

  // Implemented positions; bit 18 and bits 11:8 are reserved
  localparam logic [31:0] TTM_VALID_MASK = 32'hFFFB_F0FF;
  // Watchdog and both timers drive the fast line
  localparam logic [31:0] TTM_FAST_MASK = 32'h0000_0070;
  localparam logic [31:0] TTM_NORMAL_MASK = TTM_VALID_MASK & ~TTM_FAST_MASK;
  localparam logic [31:0] TTM_ENABLE_RESET = 32'h0000_0000;
  localparam logic [31:0] TTM_ZERO_WORD = 32'h0000_0000;

  // Highest pending tier seen by the core
  typedef enum logic [1:0] {
    TTM_TIER_NONE = 2'b00,
    TTM_TIER_NORMAL = 2'b01,
    TTM_TIER_FAST = 2'b10
  } ttm_tier_t;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [31:0] paddr;
    logic [31:0] pwdata;
  } ttm_apb_req_t;

  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } ttm_apb_rsp_t;

  // On-chip request levels, active high
  typedef struct packed {
    logic [12:0] dma_channel_sources;
    logic eth_receive_source;
    logic eth_transmit_source;
    logic serial_a_receive_source;
    logic serial_a_transmit_source;
    logic serial_b_receive_source;
    logic serial_b_transmit_source;
    logic media_access_source;
    logic watchdog_source;
    logic timer1_source;
    logic timer2_source;
  } ttm_src_t;

  // Port pin interrupt configuration, one bit per pin 3..0
  typedef struct packed {
    logic [3:0] pin_level;
    logic [3:0] port_direction_bits;
    logic [3:0] level_irq_mode;
  } ttm_port_t;

endpackage

// [logic/ttm_mask_unit.sv]
// Two-tier interrupt mask unit with APB register access
// Overview of operation
// RULE1 - Two request outputs to the core: normal line and fast line.
// RULE2 - Fast line outranks normal line; a tier output reports fast first.
// RULE3 - Fast line driven by the timer sources and the watchdog source.
// RULE4 - Every other source drives the normal line.
// RULE5 - Each source has an enable bit masking it from any request.
// RULE6 - Plain enable register is ordinary read/write of all enable bits.
// RULE7 - Reading set-enable register returns source state gated by enables.
// RULE8 - Writing ones to set-enable register sets those enables; zeros ignored.
// RULE9 - Reading clear-enable register returns raw source state.
// RULE10 - Writing ones to clear-enable register clears those enables; zeros ignored.
// RULE11 - All three registers share one 32-bit bit layout.
// RULE12 - DMA channels 1 to 13 occupy bits 31 down to 19.
// RULE13 - Ethernet receive at bit 17, Ethernet transmit at bit 16.
// RULE14 - Serial A receive/transmit bits 15/14, serial B bits 13/12.
// RULE15 - Media access controller at bit 7, watchdog at bit 6.
// RULE16 - First timer at bit 5, second timer at bit 4.
// RULE17 - Port pins 3..0 map to bits 3..0.
// RULE18 - Registers decode at FFB0_0030, FFB0_0034 and FFB0_0038 in that order.
// RULE19 - Port interrupt active while pin level equals its direction bit.
// RULE20 - Reserved bits read zero, ignore writes; lines assert on any enabled source.
`timescale 1ns/1ps

module ttm_mask_unit (
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  input wire ttm_pkg::ttm_apb_req_t apb_req_i,
  output ttm_pkg::ttm_apb_rsp_t apb_rsp_o,
  input wire ttm_pkg::ttm_src_t src_i,
  input wire ttm_pkg::ttm_port_t port_i,
  output logic irq_o,
  output logic fast_request_line_o,
  output ttm_pkg::ttm_tier_t tier_o
);
  import ttm_pkg::*;

  // Places every source at its fixed position in the shared layout
  function automatic logic [31:0] layout_sources(input ttm_src_t s, input logic [3:0] port_lvl);
    logic [31:0] v;
    v = TTM_ZERO_WORD;
    v[TTM_DMA_LSB +: TTM_DMA_COUNT] = s.dma_channel_sources; // see RULE12
    v[TTM_ETH_RX_BIT] = s.eth_receive_source; // see RULE13
    v[TTM_ETH_TX_BIT] = s.eth_transmit_source; // see RULE13
    v[TTM_SER_A_RX_BIT] = s.serial_a_receive_source; // see RULE14
    v[TTM_SER_A_TX_BIT] = s.serial_a_transmit_source; // see RULE14
    v[TTM_SER_B_RX_BIT] = s.serial_b_receive_source; // see RULE14
    v[TTM_SER_B_TX_BIT] = s.serial_b_transmit_source; // see RULE14
    v[TTM_MAC_BIT] = s.media_access_source; // see RULE15
    v[TTM_WDOG_BIT] = s.watchdog_source; // see RULE15
    v[TTM_TIMER1_BIT] = s.timer1_source; // see RULE16
    v[TTM_TIMER2_BIT] = s.timer2_source; // see RULE16
    v[TTM_PORT_LSB +: TTM_PORT_COUNT] = port_lvl; // see RULE17
    return v;
  endfunction

  // Register selector shared by the read and write paths
  typedef enum logic [1:0] {
    TTM_SEL_NONE = 2'b00,
    TTM_SEL_PLAIN = 2'b01,
    TTM_SEL_SET = 2'b10,
    TTM_SEL_CLEAR = 2'b11
  } ttm_sel_t;

  function automatic ttm_sel_t decode_addr(input logic [31:0] addr);
    ttm_sel_t sel;
    sel = TTM_SEL_NONE;
    case (addr)
      TTM_ADDR_ENABLE_PLAIN: sel = TTM_SEL_PLAIN; // see RULE18
      TTM_ADDR_ENABLE_SET: sel = TTM_SEL_SET; // see RULE18
      TTM_ADDR_ENABLE_CLEAR: sel = TTM_SEL_CLEAR; // see RULE18
      default: sel = TTM_SEL_NONE;
    endcase
    return sel;
  endfunction

  logic [31:0] enable_reg;
  logic [31:0] enable_next;
  logic [31:0] raw_reg;
  logic [3:0] port_lvl;
  logic [31:0] masked;
  logic pready_reg;
  logic pslverr_reg;
  logic [31:0] prdata_reg;
  logic irq_reg;
  logic fast_reg;
  ttm_tier_t tier_reg;
  ttm_sel_t sel;
  logic setup_phase;
  logic write_commit;

  assign sel = decode_addr(apb_req_i.paddr);
  assign setup_phase = apb_req_i.psel && !apb_req_i.penable;
  // A write lands only on the edge where the access phase sees pready
  assign write_commit = apb_req_i.psel && apb_req_i.penable && pready_reg && apb_req_i.pwrite;

  // Level-sensitive port interrupts: pin equal to its direction bit, in interrupt mode
  assign port_lvl = port_i.level_irq_mode & ~(port_i.pin_level ^ port_i.port_direction_bits); // see RULE19

  assign masked = raw_reg & enable_reg; // see RULE5

  // Raw source state, registered once so status reads and request lines agree
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      raw_reg <= TTM_ZERO_WORD;
    end else begin
      raw_reg <= layout_sources(src_i, port_lvl) & TTM_VALID_MASK; // see RULE11
    end
  end

  // Enable update; reserved positions never hold a one
  always_comb begin
    enable_next = enable_reg;
    if (write_commit) begin
      case (sel)
        TTM_SEL_PLAIN: enable_next = apb_req_i.pwdata & TTM_VALID_MASK; // see RULE6
        TTM_SEL_SET: enable_next = enable_reg | (apb_req_i.pwdata & TTM_VALID_MASK); // see RULE8
        TTM_SEL_CLEAR: enable_next = enable_reg & ~apb_req_i.pwdata; // see RULE10
        default: enable_next = enable_reg;
      endcase
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      enable_reg <= TTM_ENABLE_RESET;
    end else begin
      enable_reg <= enable_next; // see RULE20
    end
  end

  // Zero-wait slave: answer is ready in the first access cycle.
  // Read data is captured in the setup cycle, so status is one cycle old at completion.
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= TTM_ZERO_WORD;
    end else if (setup_phase) begin
      pready_reg <= 1'b1;
      pslverr_reg <= (sel == TTM_SEL_NONE); // see RULE18
      if (apb_req_i.pwrite) begin
        prdata_reg <= TTM_ZERO_WORD;
      end else begin
        case (sel)
          TTM_SEL_PLAIN: prdata_reg <= enable_reg; // see RULE6
          TTM_SEL_SET: prdata_reg <= masked; // see RULE7
          TTM_SEL_CLEAR: prdata_reg <= raw_reg; // see RULE9
          default: prdata_reg <= TTM_ZERO_WORD;
        endcase
      end
    end else begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= TTM_ZERO_WORD;
    end
  end

  // Request lines: any enabled source of each tier
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      irq_reg <= 1'b0;
      fast_reg <= 1'b0;
    end else begin
      irq_reg <= |(masked & TTM_NORMAL_MASK); // see RULE4
      fast_reg <= |(masked & TTM_FAST_MASK); // see RULE3
    end
  end

  // The core arbitrates the two lines itself; the tier output shows which wins
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      tier_reg <= TTM_TIER_NONE;
    end else if (|(masked & TTM_FAST_MASK)) begin
      tier_reg <= TTM_TIER_FAST; // see RULE2
    end else if (|(masked & TTM_NORMAL_MASK)) begin
      tier_reg <= TTM_TIER_NORMAL;
    end else begin
      tier_reg <= TTM_TIER_NONE;
    end
  end

  assign apb_rsp_o.pready = pready_reg;
  assign apb_rsp_o.pslverr = pslverr_reg;
  assign apb_rsp_o.prdata = prdata_reg;
  assign irq_o = irq_reg; // see RULE1
  assign fast_request_line_o = fast_reg; // see RULE1
  assign tier_o = tier_reg;

  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (sys_rst_i);

  sequence setup_at(logic [31:0] a, logic wr);
    apb_req_i.psel && !apb_req_i.penable && apb_req_i.paddr == a && apb_req_i.pwrite == wr;
  endsequence

  sequence commit_at(logic [31:0] a);
    write_commit && apb_req_i.paddr == a;
  endsequence

  fast_line_a: assert property (fast_request_line_o == $past(|(masked & TTM_FAST_MASK))) // see RULE3
    else $error("fast line does not follow enabled timer or watchdog sources");

  normal_line_a: assert property (irq_o == $past(|(masked & TTM_NORMAL_MASK))) // see RULE4
    else $error("normal line does not follow enabled normal sources");

  mask_gate_a: assert property (enable_reg == TTM_ZERO_WORD |=> !irq_o && !fast_request_line_o) // see RULE5
    else $error("request raised with every source disabled");

  plain_write_a: assert property (commit_at(TTM_ADDR_ENABLE_PLAIN) |=> enable_reg == $past(apb_req_i.pwdata & TTM_VALID_MASK)) // see RULE6
    else $error("plain enable write not stored");

  set_write_a: assert property (commit_at(TTM_ADDR_ENABLE_SET)
    |=> enable_reg == ($past(enable_reg) | $past(apb_req_i.pwdata & TTM_VALID_MASK))) // see RULE8
    else $error("set-enable write wrong");

  clear_write_a: assert property (commit_at(TTM_ADDR_ENABLE_CLEAR)
    |=> enable_reg == ($past(enable_reg) & ~$past(apb_req_i.pwdata))) // see RULE10
    else $error("clear-enable write wrong");

  masked_read_a: assert property (setup_at(TTM_ADDR_ENABLE_SET, 1'b0)
    |=> apb_rsp_o.pready && apb_rsp_o.prdata == $past(raw_reg & enable_reg)) // see RULE7
    else $error("masked status read wrong");

  raw_read_a: assert property (setup_at(TTM_ADDR_ENABLE_CLEAR, 1'b0)
    |=> apb_rsp_o.pready && apb_rsp_o.prdata == $past(raw_reg)) // see RULE9
    else $error("raw status read wrong");

  reserved_zero_a: assert property ((enable_reg & ~TTM_VALID_MASK) == TTM_ZERO_WORD
    && (raw_reg & ~TTM_VALID_MASK) == TTM_ZERO_WORD) // see RULE20
    else $error("reserved bit holds a one");

  tier_prio_a: assert property (fast_request_line_o |-> tier_o == TTM_TIER_FAST) // see RULE2
    else $error("fast request not reported as top tier");

  port_level_a: assert property (raw_reg[TTM_PORT_LSB +: TTM_PORT_COUNT]
    == $past(port_i.level_irq_mode & ~(port_i.pin_level ^ port_i.port_direction_bits))) // see RULE19
    else $error("port level interrupt wrong");

  unmapped_a: assert property (setup_phase && sel == TTM_SEL_NONE |=> apb_rsp_o.pslverr && apb_rsp_o.prdata == TTM_ZERO_WORD) // see RULE18
    else $error("unmapped address not refused");

  // Every source must land at its own position of the shared layout
  dma_pos_a: assert property (raw_reg[TTM_DMA_LSB +: TTM_DMA_COUNT] == $past(src_i.dma_channel_sources)) // see RULE12
    else $error("channel sources not at their field");

  eth_rx_pos_a: assert property (raw_reg[TTM_ETH_RX_BIT] == $past(src_i.eth_receive_source)) // see RULE13
    else $error("receive source at wrong bit");

  eth_tx_pos_a: assert property (raw_reg[TTM_ETH_TX_BIT] == $past(src_i.eth_transmit_source)) // see RULE13
    else $error("transmit source at wrong bit");

  ser_a_rx_a: assert property (raw_reg[TTM_SER_A_RX_BIT] == $past(src_i.serial_a_receive_source)) // see RULE14
    else $error("serial A receive at wrong bit");

  ser_a_tx_a: assert property (raw_reg[TTM_SER_A_TX_BIT] == $past(src_i.serial_a_transmit_source)) // see RULE14
    else $error("serial A transmit at wrong bit");

  ser_b_rx_a: assert property (raw_reg[TTM_SER_B_RX_BIT] == $past(src_i.serial_b_receive_source)) // see RULE14
    else $error("serial B receive at wrong bit");

  ser_b_tx_a: assert property (raw_reg[TTM_SER_B_TX_BIT] == $past(src_i.serial_b_transmit_source)) // see RULE14
    else $error("serial B transmit at wrong bit");

  mac_pos_a: assert property (raw_reg[TTM_MAC_BIT] == $past(src_i.media_access_source)) // see RULE15
    else $error("media access source at wrong bit");

  wdog_pos_a: assert property (raw_reg[TTM_WDOG_BIT] == $past(src_i.watchdog_source)) // see RULE15
    else $error("watchdog source at wrong bit");

  timer1_pos_a: assert property (raw_reg[TTM_TIMER1_BIT] == $past(src_i.timer1_source)) // see RULE16
    else $error("first timer at wrong bit");

  timer2_pos_a: assert property (raw_reg[TTM_TIMER2_BIT] == $past(src_i.timer2_source)) // see RULE16
    else $error("second timer at wrong bit");

  // A pin is active only in interrupt mode and while its level matches its direction bit
  pin0_level_a: assert property (raw_reg[TTM_PORT_LSB] == $past(port_i.level_irq_mode[0] // see RULE17 RULE19
    && port_i.pin_level[0] == port_i.port_direction_bits[0]))
    else $error("pin 0 condition wrong");

  pin1_level_a: assert property (raw_reg[TTM_PORT_LSB + 1] == $past(port_i.level_irq_mode[1] // see RULE17 RULE19
    && port_i.pin_level[1] == port_i.port_direction_bits[1]))
    else $error("pin 1 condition wrong");

  pin2_level_a: assert property (raw_reg[TTM_PORT_LSB + 2] == $past(port_i.level_irq_mode[2] // see RULE17 RULE19
    && port_i.pin_level[2] == port_i.port_direction_bits[2]))
    else $error("pin 2 condition wrong");

  pin3_level_a: assert property (raw_reg[TTM_PORT_LSB + 3] == $past(port_i.level_irq_mode[3] // see RULE17 RULE19
    && port_i.pin_level[3] == port_i.port_direction_bits[3]))
    else $error("pin 3 condition wrong");

  // A transfer is a setup cycle followed by an access cycle that sees the answer
  sequence access_done;
    apb_req_i.psel && apb_req_i.penable && apb_rsp_o.pready;
  endsequence

  sequence read_xfer(logic [31:0] a);
    setup_at(a, 1'b0) ##1 access_done;
  endsequence

  sequence write_xfer(logic [31:0] a);
    setup_at(a, 1'b1) ##1 commit_at(a);
  endsequence

  plain_read_a: assert property (read_xfer(TTM_ADDR_ENABLE_PLAIN) // see RULE6
    |-> apb_rsp_o.prdata == $past(enable_reg))
    else $error("plain enable read wrong");

  set_read_a: assert property (read_xfer(TTM_ADDR_ENABLE_SET) // see RULE7
    |-> apb_rsp_o.prdata == ($past(raw_reg) & $past(enable_reg)))
    else $error("masked status transfer wrong");

  clear_read_a: assert property (read_xfer(TTM_ADDR_ENABLE_CLEAR) // see RULE9
    |-> apb_rsp_o.prdata == $past(raw_reg))
    else $error("raw status transfer wrong");

  plain_xfer_a: assert property (write_xfer(TTM_ADDR_ENABLE_PLAIN) // see RULE6
    |=> enable_reg == $past(apb_req_i.pwdata & TTM_VALID_MASK))
    else $error("plain enable transfer not stored");

  clear_xfer_a: assert property (write_xfer(TTM_ADDR_ENABLE_CLEAR) // see RULE10
    |=> enable_reg == ($past(enable_reg) & ~$past(apb_req_i.pwdata)))
    else $error("clear-enable transfer wrong");

  // Zero-wait answer that stands for one cycle only
  ready_next_a: assert property (setup_phase |=> apb_rsp_o.pready) // see RULE18
    else $error("no answer after setup");

  ready_pulse_a: assert property (apb_rsp_o.pready |=> !apb_rsp_o.pready) // see RULE18
    else $error("answer held too long");

  ready_idle_a: assert property (!setup_phase |=> !apb_rsp_o.pready && apb_rsp_o.prdata == TTM_ZERO_WORD) // see RULE18
    else $error("answer without setup");

  err_ready_a: assert property (apb_rsp_o.pslverr |-> apb_rsp_o.pready) // see RULE18
    else $error("error without answer");

  mapped_ok_a: assert property (setup_phase && sel != TTM_SEL_NONE |=> !apb_rsp_o.pslverr) // see RULE18
    else $error("mapped address refused");

  write_zero_a: assert property (setup_phase && apb_req_i.pwrite |=> apb_rsp_o.prdata == TTM_ZERO_WORD) // see RULE6
    else $error("write returned data");

  // Enables move only on a committed write to a mapped place
  enable_hold_a: assert property (!write_commit |=> enable_reg == $past(enable_reg)) // see RULE6
    else $error("enables changed without a write");

  stray_keep_a: assert property (write_commit && sel == TTM_SEL_NONE // see RULE18
    |=> enable_reg == $past(enable_reg))
    else $error("unmapped write changed enables");

  set_keep_a: assert property (commit_at(TTM_ADDR_ENABLE_SET) // see RULE8
    |=> (enable_reg & $past(enable_reg)) == $past(enable_reg))
    else $error("set-enable write cleared a bit");

  clear_keep_a: assert property (commit_at(TTM_ADDR_ENABLE_CLEAR) // see RULE10
    |=> (enable_reg & ~$past(enable_reg)) == TTM_ZERO_WORD)
    else $error("clear-enable write set a bit");

  // Lines must stay low when none of their own sources is enabled
  fast_quiet_a: assert property ((enable_reg & TTM_FAST_MASK) == TTM_ZERO_WORD |=> !fast_request_line_o) // see RULE3
    else $error("fast line raised by a normal source");

  normal_quiet_a: assert property ((enable_reg & TTM_NORMAL_MASK) == TTM_ZERO_WORD |=> !irq_o) // see RULE4
    else $error("normal line raised by a fast source");

  tier_fast_a: assert property (tier_o == TTM_TIER_FAST |-> fast_request_line_o) // see RULE2
    else $error("fast tier shown with fast line low");

  tier_normal_a: assert property (tier_o == TTM_TIER_NORMAL |-> irq_o && !fast_request_line_o) // see RULE2
    else $error("normal tier shown with fast pending");

  tier_none_a: assert property (tier_o == TTM_TIER_NONE |-> !irq_o && !fast_request_line_o) // see RULE1
    else $error("idle tier shown with a line raised");

endmodule // ttm_mask_unit

// [verification/ttm_src_model.sv]
// Source-side model: turns a register-layout word into source and port pin levels
`timescale 1ns/1ps
module ttm_src_model (
  input wire logic [31:0] want_i,
  input wire logic [3:0] dir_i,
  input wire logic [3:0] mode_i,
  output ttm_pkg::ttm_src_t src_o,
  output ttm_pkg::ttm_port_t port_o
);
  import ttm_pkg::*;
  assign src_o = {want_i[31:19], want_i[17:12], want_i[7:4]};
  // Pin equals its direction bit only where that source should be active
  assign port_o = {dir_i ^ ~want_i[3:0], dir_i, mode_i};
endmodule // ttm_src_model

// [verification/tb_top.sv]
// Self-checking bench for the two-tier interrupt mask unit
`timescale 1ns/1ps
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin fail_count++; \
  $display("[FAIL] t=%0t got=%0h exp=%0h", $time, (a), (e)); end end
module tb_top;
  import ttm_pkg::*;
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  ttm_apb_req_t req = '0;
  ttm_apb_rsp_t rsp;
  ttm_src_t src;
  ttm_port_t port;
  logic irq;
  logic fast;
  ttm_tier_t tier;
  logic [31:0] want = '0;
  logic [31:0] en;
  logic [31:0] v;
  logic [31:0] p;
  logic [3:0] dir = '0;
  logic [3:0] mode = '0;
  logic [32:0] mon_e;
  logic [32:0] expq[$];
  logic [31:0] bad_addr[4] = '{32'hFFB0_002C, 32'hFFB0_003C, 32'h0000_0030, 32'hFFB0_0032};
  int fail_count = 0;
  int check_count = 0;
  always #50 core_clk = ~core_clk;
  ttm_src_model i_ttm_src_model (.want_i(want), .dir_i(dir), .mode_i(mode), .src_o(src), .port_o(port));
  ttm_mask_unit i_ttm_mask_unit (.core_clk_i(core_clk), .sys_rst_i(sys_rst), .apb_req_i(req), .apb_rsp_o(rsp),
    .src_i(src), .port_i(port), .irq_o(irq), .fast_request_line_o(fast), .tier_o(tier));
  task automatic final_report;
    $display("checks=%0d mismatches=%0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // Every transfer notes its expected {pslverr, prdata}; writes expect zero data
  task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d, input logic [32:0] e);
    int n;
    n = 0;
    @(posedge core_clk);
    expq.push_back(e);
    req.psel <= 1'b1;
    req.penable <= 1'b0;
    req.pwrite <= wr;
    req.paddr <= a;
    req.pwdata <= d;
    @(posedge core_clk);
    req.penable <= 1'b1;
    do begin
      @(posedge core_clk);
      n++;
    end while (rsp.pready !== 1'b1 && n < 20);
    if (rsp.pready !== 1'b1) begin
      fail_count++;
      final_report();
    end
    req.psel <= 1'b0;
    req.penable <= 1'b0;
  endtask
  always @(posedge core_clk) begin
    if (rsp.pready === 1'b1) begin
      mon_e = (expq.size() > 0) ? expq.pop_front() : 33'h1_DEAD_BEEF;
      `CHK({rsp.pslverr, rsp.prdata}, mon_e)
    end
  end
  function automatic logic [31:0] raw();
    return {want[31:4], want[3:0] & mode} & TTM_VALID_MASK;
  endfunction
  task automatic settle;
    repeat (3) @(negedge core_clk);
  endtask
  // New source levels land on a clock edge with a random pin direction
  task automatic set_src(input logic [31:0] w, input logic [3:0] m);
    @(posedge core_clk);
    want <= w;
    mode <= m;
    dir <= 4'($urandom);
    settle();
  endtask
  task automatic chk_lines;
    logic [31:0] a;
    ttm_tier_t t;
    a = raw() & en;
    t = |(a & TTM_FAST_MASK) ? TTM_TIER_FAST : (|(a & TTM_NORMAL_MASK) ? TTM_TIER_NORMAL : TTM_TIER_NONE);
    `CHK(irq, |(a & TTM_NORMAL_MASK))
    `CHK(fast, |(a & TTM_FAST_MASK))
    `CHK(tier, t)
  endtask
  task automatic rd_all;
    apb(1'b0, TTM_ADDR_ENABLE_PLAIN, '0, {1'b0, en});
    apb(1'b0, TTM_ADDR_ENABLE_SET, '0, {1'b0, raw() & en});
    apb(1'b0, TTM_ADDR_ENABLE_CLEAR, '0, {1'b0, raw()});
  endtask
  initial begin
    void'($urandom(61));
    repeat (10) @(posedge core_clk);
    sys_rst <= 1'b0;
    en = TTM_ENABLE_RESET;
    rd_all();
    apb(1'b1, TTM_ADDR_ENABLE_PLAIN, '1, '0);
    en = TTM_VALID_MASK;
    // Walking one shows each source at its own bit and on its own line
    for (int b = 0; b < 32; b++) begin
      set_src(32'h1 << b, 4'hF);
      rd_all();
      settle();
      chk_lines();
    end
    for (int i = 0; i < 40; i++) begin
      v = $urandom;
      set_src($urandom, 4'($urandom));
      apb(1'b1, TTM_ADDR_ENABLE_PLAIN, v, '0);
      en = v & TTM_VALID_MASK;
      p = $urandom;
      apb(1'b1, TTM_ADDR_ENABLE_SET, p, '0);
      en = en | (p & TTM_VALID_MASK);
      p = $urandom;
      if (i % 2 == 0) begin
        apb(1'b1, TTM_ADDR_ENABLE_CLEAR, p, '0);
        en = en & ~p;
      end
      rd_all();
      settle();
      chk_lines();
    end
    // Unmapped places answer with an error and leave the enables alone
    foreach (bad_addr[k]) begin
      apb(1'b1, bad_addr[k], '1, {1'b1, TTM_ZERO_WORD});
      apb(1'b0, bad_addr[k], '0, {1'b1, TTM_ZERO_WORD});
    end
    apb(1'b1, 32'hFFB0_003C, '1, {1'b1, TTM_ZERO_WORD});
    apb(1'b1, 32'h0000_0030, '1, {1'b1, TTM_ZERO_WORD});
    apb(1'b0, 32'hFFB0_002C, '0, {1'b1, TTM_ZERO_WORD});
    rd_all();
    set_src('1, 4'hF);
    apb(1'b1, TTM_ADDR_ENABLE_CLEAR, '1, '0);
    en = '0;
    settle();
    chk_lines();
    `CHK(32'(expq.size()), 32'h0)
    final_report();
  end
endmodule // tb_top
